/* File: counter_io_cfg.svh */
// How it works
// - tc output pulses or toggles per terminal count
// - software picks tc output polarity
// - all outputs stay high impedance until enabled
// - counter0 pin low counts down, high up
// - counter0 pin can yield direction to software
// - counter1 pin low counts down, high up
// - counter1 pin can yield direction to software
// - source from any function pin, chosen edge
// - counter1 source monitor copies applied source
// - otherwise source is 20 MHz or 100 kHz
// - gate from any function pin, chosen edge
// - gate starts/stops, flags or latches count
// - counter1 gate monitor copies applied gate
// - gate and output act on active edge
// - async gate may slip one source period
// - 4-bit divider divides by 1 to 16
// - divider input is 10 MHz or 100 kHz
// - software picks divider output polarity
// - counter0 monitors copy applied source and gate
`ifndef COUNTER_IO_CFG_SVH
`define COUNTER_IO_CFG_SVH

// widths
`define NUM_PFI 10
`define NUM_PIN 12
`define CNT_W 24
`define ADDR_W 8

// register byte offsets, counter 1 sits one stride above counter 0
`define CTR_STRIDE 8'h20
`define REG_CFG 8'h00
`define REG_LOAD 8'h04
`define REG_COUNT 8'h08
`define REG_LATCH 8'h0C
`define REG_STATUS 8'h10
`define REG_DIV 8'h40
`define REG_MASK 8'h1F

// source select codes beyond the function pins
`define SEL_TB20 4'hA
`define SEL_TB100 4'hB

// status fields
`define ST_TC 0
`define ST_GATE 1
`define ST_RUN 2
`define ST_PIN 3
`define ST_UP 4

// reset values
`define CFG_RST 19'h00000
`define DIV_RST 7'h00

// timebases
`define CLK_HZ 20000000
`define TB100_HZ 100000
`define TB100_DIV (`CLK_HZ / `TB100_HZ)
`define TB100_HALF (`TB100_DIV / 2)

`endif

/* File: counter_io_pkg.sv */
`include "counter_io_cfg.svh"

package counter_io_pkg;

    typedef enum logic [1:0] {
        GATE_STARTSTOP = 2'b00,
        GATE_LATCH = 2'b01,
        GATE_FLAG = 2'b10,
        GATE_NONE = 2'b11
    } gate_mode_type;

    // counter configuration word, lsb first from src_sel
    typedef struct packed {
        logic mon_en;
        logic out_en;
        logic run_en;
        logic sw_up;
        logic dir_ext;
        logic out_pol;
        logic out_toggle;
        gate_mode_type gate_mode;
        logic gate_fall;
        logic [3:0] gate_sel;
        logic src_fall;
        logic [3:0] src_sel;
    } ctr_cfg_type;

    typedef struct packed {
        logic oe;
        logic pol;
        logic src_100k;
        logic [3:0] div_m1;
    } div_cfg_type;

    typedef struct packed {
        ctr_cfg_type cfg;
        ctr_cfg_type act;
        logic [`CNT_W-1:0] load;
        logic [`CNT_W-1:0] count;
        logic [`CNT_W-1:0] latch;
        logic gate_open;
        logic tc_lvl;
        logic tc_out;
        logic src_prev;
        logic gate_prev;
        logic gate_pend;
        logic tc_flag;
        logic gate_flag;
        logic src_mon;
        logic gate_mon;
        logic oe;
        logic mon_oe;
    } ctr_state_type;

    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [`ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_state_type;

    typedef struct packed {
        logic [`NUM_PIN-1:0] s1;
        logic [`NUM_PIN-1:0] s2;
        logic [`NUM_PIN-1:0] s3;
        logic [`NUM_PIN-1:0] stable;
        ctr_state_type [1:0] ctr;
        axi_state_type axi;
        logic [7:0] c100;
        logic tb10;
        logic [3:0] dcnt;
        div_cfg_type div;
        logic div_out;
        logic div_oe;
    } top_state_type;

endpackage : counter_io_pkg

/* File: field_signal_model.sv */
`timescale 1ns/1ns
`default_nettype none
module field_signal_model (
    input wire logic aclk,
    output logic [9:0] pins
);
    logic [7:0] tick_r = 8'h00;
    logic [9:0] pins_r = 10'h000;
    assign pins = pins_r;
    // staggered squares, half period 8 (16 on pins 8, 9): slow enough
    // that the three-flop synchroniser never merges two edges
    always_ff @(posedge aclk) begin
        tick_r <= tick_r + 8'h01;
        for (int k = 0; k < 10; k++) begin
            if (k < 8 ? tick_r[2:0] == k[2:0] : tick_r[3:0] == k[3:0]) begin
                pins_r[k] <= ~pins_r[k];
            end
        end
    end
endmodule : field_signal_model
`default_nettype wire

/* File: general_purpose_counter_io.sv */
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "counter_io_cfg.svh"

module general_purpose_counter_io
    import counter_io_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`NUM_PFI-1:0] programmable_function_pin,
    input wire logic digital_pin_six,
    input wire logic digital_pin_seven,
    output logic counter0_tc_out,
    output logic counter0_tc_oe,
    output logic counter1_tc_out,
    output logic counter1_tc_oe,
    output logic counter0_clk_src_mon,
    output logic counter0_gate_in_mon,
    output logic counter0_mon_oe,
    output logic counter1_clk_src_mon,
    output logic counter1_gate_in_mon,
    output logic counter1_mon_oe,
    output logic divider_out,
    output logic divider_oe
);

    top_state_type r;
    top_state_type n;
    logic [1:0] src_lvl;
    logic [1:0] src_tick;
    logic [1:0] gate_lvl;
    logic [1:0] gate_edge;
    logic [1:0] gate_apply;
    logic [1:0] dir_up;
    logic [1:0] running;
    logic [1:0] tc_hit;
    logic tb100_lvl;
    logic div_rise;
    logic div_lvl;

    // ****************************************
    // helpers
    // ****************************************

    // true for every mapped register byte address
    function automatic logic reg_ok(input logic [`ADDR_W-1:0] a);
        logic [`ADDR_W-1:0] off;
        off = a & `REG_MASK;
        if (a == `REG_DIV) begin
            return 1'b1;
        end
        if (a >= 2 * `CTR_STRIDE) begin
            return 1'b0;
        end
        return (off == `REG_CFG) || (off == `REG_LOAD) ||
            (off == `REG_COUNT) || (off == `REG_LATCH) ||
            (off == `REG_STATUS);
    endfunction : reg_ok

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // edge of a level in the chosen direction
    function automatic logic edge_of(input logic prev, input logic lvl,
        input logic fall);
        return fall ? (prev & ~lvl) : (~prev & lvl);
    endfunction : edge_of

    // ****************************************
    // next state
    // ****************************************

    // one pass over pins, timebases, counters, divider and bus
    always_comb begin
        logic [31:0] rd;
        logic [`ADDR_W-1:0] off;
        logic [`ADDR_W-1:0] blk;
        logic [31:0] wv;
        logic [31:0] st;
        rd = 32'h0000_0000;
        off = '0;
        blk = '0;
        wv = 32'h0000_0000;
        st = 32'h0000_0000;
        n = r;
        src_lvl = 2'b00;
        src_tick = 2'b00;
        gate_lvl = 2'b00;
        gate_edge = 2'b00;
        gate_apply = 2'b00;
        dir_up = 2'b00;
        running = 2'b00;
        tc_hit = 2'b00;

        // three-stage pin capture; a level counts once stages 2 and 3 agree
        n.s1 = {digital_pin_seven, digital_pin_six, programmable_function_pin};
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < `NUM_PIN; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.stable[i] = r.s3[i];
            end
        end

        // internal timebases: 10 MHz square and 100 kHz square
        n.tb10 = ~r.tb10;
        n.c100 = (r.c100 == 8'(`TB100_DIV - 1)) ? 8'h00 : r.c100 + 8'h01;
        tb100_lvl = r.c100 < 8'(`TB100_HALF);

        for (int k = 0; k < 2; k++) begin
            // source pick, pin or internal timebase
            // the 20 MHz base ticks every cycle; its monitor shows 10 MHz
            if (r.ctr[k].cfg.src_sel < 4'(`NUM_PFI)) begin
                src_lvl[k] = r.stable[r.ctr[k].cfg.src_sel];
                src_tick[k] = edge_of(r.ctr[k].src_prev, src_lvl[k],
                    r.ctr[k].cfg.src_fall);
            end else if (r.ctr[k].cfg.src_sel == `SEL_TB20) begin
                src_lvl[k] = r.tb10;
                src_tick[k] = 1'b1;
            end else begin
                src_lvl[k] = tb100_lvl;
                src_tick[k] = r.ctr[k].cfg.src_fall ?
                    (r.c100 == 8'(`TB100_HALF)) : (r.c100 == 8'h00);
            end
            n.ctr[k].src_prev = src_lvl[k];

            // gate pick and edge; no pin selected means gate held low
            if (r.ctr[k].cfg.gate_sel < 4'(`NUM_PFI)) begin
                gate_lvl[k] = r.stable[r.ctr[k].cfg.gate_sel];
            end
            gate_edge[k] = edge_of(r.ctr[k].gate_prev, gate_lvl[k],
                r.ctr[k].cfg.gate_fall);
            n.ctr[k].gate_prev = gate_lvl[k];

            // direction from pin or software bit
            dir_up[k] = r.ctr[k].act.dir_ext ? r.stable[`NUM_PFI + k]
                : r.ctr[k].act.sw_up;
            running[k] = r.ctr[k].act.run_en &&
                (r.ctr[k].act.gate_mode != GATE_STARTSTOP ||
                r.ctr[k].gate_open);
            tc_hit[k] = src_tick[k] && running[k] && (dir_up[k] ?
                (r.ctr[k].count == r.ctr[k].load) :
                (r.ctr[k].count == '0));

            // a gate edge waits for the next source tick, so an
            // unsynchronised gate may land one period late
            gate_apply[k] = src_tick[k] && r.ctr[k].gate_pend;
            if (gate_edge[k]) begin
                n.ctr[k].gate_pend = 1'b1;
            end

            if (src_tick[k]) begin
                n.ctr[k].act = r.ctr[k].cfg;
                n.ctr[k].gate_pend = gate_edge[k];
                if (gate_apply[k]) begin
                    unique case (r.ctr[k].act.gate_mode)
                        GATE_STARTSTOP: n.ctr[k].gate_open =
                            ~r.ctr[k].gate_open;
                        GATE_LATCH: n.ctr[k].latch = r.ctr[k].count;
                        GATE_FLAG: n.ctr[k].gate_flag = 1'b1;
                        GATE_NONE: ;
                    endcase
                end
                if (!r.ctr[k].act.run_en) begin
                    n.ctr[k].count = dir_up[k] ? '0 : r.ctr[k].load;
                    n.ctr[k].gate_open = 1'b0;
                end else if (tc_hit[k]) begin
                    n.ctr[k].count = dir_up[k] ? '0 : r.ctr[k].load;
                end else if (running[k]) begin
                    n.ctr[k].count = dir_up[k] ? r.ctr[k].count + 1'b1
                        : r.ctr[k].count - 1'b1;
                end
                // pulse holds one source period, toggle flips once
                if (r.ctr[k].act.out_toggle) begin
                    n.ctr[k].tc_lvl = r.ctr[k].tc_lvl ^ tc_hit[k];
                end else begin
                    n.ctr[k].tc_lvl = tc_hit[k];
                end
            end
            if (tc_hit[k]) begin
                n.ctr[k].tc_flag = 1'b1;
            end
            n.ctr[k].tc_out = n.ctr[k].tc_lvl ^ n.ctr[k].act.out_pol;

            // monitors repeat the applied source and gate
            n.ctr[k].src_mon = src_lvl[k];
            n.ctr[k].gate_mon = gate_lvl[k];
            n.ctr[k].oe = r.ctr[k].cfg.out_en;
            n.ctr[k].mon_oe = r.ctr[k].cfg.mon_en;
        end

        // divider: 4-bit count of base rises, divide by div_m1 + 1
        div_rise = r.div.src_100k ? (r.c100 == 8'h00) : !r.tb10;
        if (div_rise) begin
            n.dcnt = (r.dcnt >= r.div.div_m1) ? 4'h0 : r.dcnt + 4'h1;
        end
        if (r.div.div_m1 == 4'h0) begin
            div_lvl = r.div.src_100k ? (n.c100 < 8'(`TB100_HALF)) : n.tb10;
        end else begin
            div_lvl = {1'b0, n.dcnt} < ({1'b0, r.div.div_m1} + 5'h01) >> 1;
        end
        n.div_out = div_lvl ^ r.div.pol;
        n.div_oe = r.div.oe;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && r.axi.awready) begin
            n.axi.aw_ok = 1'b1;
            n.axi.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.axi.wready) begin
            n.axi.w_ok = 1'b1;
            n.axi.wdata = s_axi_wdata;
            n.axi.wstrb = s_axi_wstrb;
        end
        if (r.axi.bvalid && s_axi_bready) begin
            n.axi.bvalid = 1'b0;
        end
        if (r.axi.aw_ok && r.axi.w_ok && !r.axi.bvalid) begin
            n.axi.aw_ok = 1'b0;
            n.axi.w_ok = 1'b0;
            n.axi.bvalid = 1'b1;
            n.axi.bresp = reg_ok(r.axi.awaddr) ? 2'b00 : 2'b10;
            off = r.axi.awaddr & `REG_MASK;
            blk = r.axi.awaddr >> 5;
            if (r.axi.awaddr == `REG_DIV) begin
                wv = merge({25'h0, r.div}, r.axi.wdata, r.axi.wstrb);
                n.div = div_cfg_type'(wv[6:0]);
            end else if (reg_ok(r.axi.awaddr)) begin
                for (int k = 0; k < 2; k++) begin
                    if (blk == `ADDR_W'(k) && off == `REG_CFG) begin
                        wv = merge({13'h0, r.ctr[k].cfg}, r.axi.wdata,
                            r.axi.wstrb);
                        n.ctr[k].cfg = ctr_cfg_type'(wv[18:0]);
                    end
                    if (blk == `ADDR_W'(k) && off == `REG_LOAD) begin
                        wv = merge({8'h00, r.ctr[k].load}, r.axi.wdata,
                            r.axi.wstrb);
                        n.ctr[k].load = wv[`CNT_W-1:0];
                    end
                    // write one to clear; a set in the same cycle wins
                    if (blk == `ADDR_W'(k) && off == `REG_STATUS &&
                        r.axi.wstrb[0]) begin
                        if (r.axi.wdata[`ST_TC] && !tc_hit[k]) begin
                            n.ctr[k].tc_flag = 1'b0;
                        end
                        if (r.axi.wdata[`ST_GATE] && !(gate_apply[k] &&
                            r.ctr[k].act.gate_mode == GATE_FLAG)) begin
                            n.ctr[k].gate_flag = 1'b0;
                        end
                    end
                end
            end
        end
        n.axi.awready = ~n.axi.aw_ok;
        n.axi.wready = ~n.axi.w_ok;

        // read channel: one read in flight, answered next cycle
        if (r.axi.rvalid && s_axi_rready) begin
            n.axi.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.axi.arready) begin
            off = s_axi_araddr & `REG_MASK;
            blk = s_axi_araddr >> 5;
            if (s_axi_araddr == `REG_DIV) begin
                rd = {25'h0, r.div};
            end else if (reg_ok(s_axi_araddr)) begin
                for (int k = 0; k < 2; k++) begin
                    if (blk == `ADDR_W'(k)) begin
                        st = 32'h0000_0000;
                        st[`ST_TC] = r.ctr[k].tc_flag;
                        st[`ST_GATE] = r.ctr[k].gate_flag;
                        st[`ST_RUN] = running[k];
                        // pin free for general use when direction is software
                        st[`ST_PIN] = r.stable[`NUM_PFI + k];
                        st[`ST_UP] = dir_up[k];
                        unique case (off)
                            `REG_CFG: rd = {13'h0, r.ctr[k].cfg};
                            `REG_LOAD: rd = {8'h00, r.ctr[k].load};
                            `REG_COUNT: rd = {8'h00, r.ctr[k].count};
                            `REG_LATCH: rd = {8'h00, r.ctr[k].latch};
                            default: rd = st;
                        endcase
                    end
                end
            end
            n.axi.rvalid = 1'b1;
            n.axi.rdata = rd;
            n.axi.rresp = reg_ok(s_axi_araddr) ? 2'b00 : 2'b10;
        end
        n.axi.arready = ~n.axi.rvalid;
    end

    // ****************************************
    // state register
    // ****************************************

    // all-zero reset: every output disabled, bus not ready for one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready = r.axi.awready;
    assign s_axi_wready = r.axi.wready;
    assign s_axi_bvalid = r.axi.bvalid;
    assign s_axi_bresp = r.axi.bresp;
    assign s_axi_arready = r.axi.arready;
    assign s_axi_rvalid = r.axi.rvalid;
    assign s_axi_rdata = r.axi.rdata;
    assign s_axi_rresp = r.axi.rresp;
    assign counter0_tc_out = r.ctr[0].tc_out;
    assign counter0_tc_oe = r.ctr[0].oe;
    assign counter1_tc_out = r.ctr[1].tc_out;
    assign counter1_tc_oe = r.ctr[1].oe;
    assign counter0_clk_src_mon = r.ctr[0].src_mon;
    assign counter0_gate_in_mon = r.ctr[0].gate_mon;
    assign counter0_mon_oe = r.ctr[0].mon_oe;
    assign counter1_clk_src_mon = r.ctr[1].src_mon;
    assign counter1_gate_in_mon = r.ctr[1].gate_mon;
    assign counter1_mon_oe = r.ctr[1].mon_oe;
    assign divider_out = r.div_out;
    assign divider_oe = r.div_oe;

    // ****************************************
    // checks
    // ****************************************

    property p_oe_off;
        @(posedge aclk) disable iff (!aresetn)
        !r.ctr[0].cfg.out_en && !r.div.oe |=> !counter0_tc_oe && !divider_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven early");

    property p_toggle;
        @(posedge aclk) disable iff (!aresetn)
        tc_hit[0] && r.ctr[0].act.out_toggle &&
        r.ctr[0].cfg.out_pol == r.ctr[0].act.out_pol
        |=> counter0_tc_out != $past(counter0_tc_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_pulse;
        @(posedge aclk) disable iff (!aresetn)
        tc_hit[1] && !r.ctr[1].act.out_toggle &&
        r.ctr[1].cfg.out_pol == r.ctr[1].act.out_pol
        |=> counter1_tc_out == ~$past(r.ctr[1].act.out_pol);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse missed");

    property p_down0;
        @(posedge aclk) disable iff (!aresetn)
        src_tick[0] && running[0] && r.ctr[0].act.dir_ext &&
        !r.stable[`NUM_PFI] && r.ctr[0].count != '0
        |=> r.ctr[0].count == $past(r.ctr[0].count) - 1'b1;
    endproperty
    a_down0: assert property (p_down0) else $error("no count down");

    property p_up1;
        @(posedge aclk) disable iff (!aresetn)
        src_tick[1] && running[1] && r.ctr[1].act.dir_ext &&
        r.stable[`NUM_PFI + 1] && r.ctr[1].count != r.ctr[1].load
        |=> r.ctr[1].count == $past(r.ctr[1].count) + 1'b1;
    endproperty
    a_up1: assert property (p_up1) else $error("no count up");

    property p_div_range;
        @(posedge aclk) disable iff (!aresetn)
        div_rise |=> r.dcnt <= $past(r.div.div_m1);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider range");

    property p_src_mon;
        @(posedge aclk) disable iff (!aresetn)
        src_lvl[1] != gate_lvl[1] |=>
        counter1_clk_src_mon == $past(src_lvl[1]) &&
        counter1_gate_in_mon == $past(gate_lvl[1]);
    endproperty
    a_src_mon: assert property (p_src_mon) else $error("monitor wrong");

    property p_latch;
        @(posedge aclk) disable iff (!aresetn)
        gate_apply[0] && r.ctr[0].act.gate_mode == GATE_LATCH
        |=> r.ctr[0].latch == $past(r.ctr[0].count);
    endproperty
    a_latch: assert property (p_latch) else $error("latch missed");

    property p_cfg_apply;
        @(posedge aclk) disable iff (!aresetn)
        src_tick[1] |=> r.ctr[1].act == $past(r.ctr[1].cfg);
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) else $error("cfg late");

endmodule : general_purpose_counter_io

`default_nettype wire

/* File: general_purpose_counter_io_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module general_purpose_counter_io_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, rb;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [9:0] programmable_function_pin;
    logic digital_pin_six = 1'b0, digital_pin_seven = 1'b0;
    logic counter0_tc_out, counter0_tc_oe, counter1_tc_out, counter1_tc_oe;
    logic counter0_clk_src_mon, counter0_gate_in_mon, counter0_mon_oe;
    logic counter1_clk_src_mon, counter1_gate_in_mon, counter1_mon_oe;
    logic divider_out, divider_oe, t, s, g, lt, ls, lg;
    logic [7:0] b;
    logic [3:0] m1;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 32'h7A8A;
    int nt, ns, ng, nh, per;

    general_purpose_counter_io general_purpose_counter_io_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .programmable_function_pin,
        .digital_pin_six, .digital_pin_seven, .counter0_tc_out,
        .counter0_tc_oe, .counter1_tc_out, .counter1_tc_oe,
        .counter0_clk_src_mon, .counter0_gate_in_mon, .counter0_mon_oe,
        .counter1_clk_src_mon, .counter1_gate_in_mon, .counter1_mon_oe,
        .divider_out, .divider_oe
    );
    field_signal_model field_signal_model_inst (
        .aclk,
        .pins(programmable_function_pin)
    );

    // ****************
    // bus and checking
    // ****************
    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check

    // valids drop only on a real handshake, so a following call never
    // assigns the same signal twice in one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        e = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        e = s_axi_rresp;
    endtask : rd

    function automatic logic dir_up(input logic ext, pin, sw);
        return ext ? pin : sw;
    endfunction : dir_up

    // counts over a window may be off by an edge at either end
    function automatic logic near(input int x, input int e);
        return x >= e - 2 && x <= e + 2;
    endfunction : near

    task automatic results;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // *********
    // scenarios
    // *********
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check({counter0_tc_oe, counter1_tc_oe, counter0_mon_oe,
               counter1_mon_oe, divider_oe}, 5'h0);
        rd(8'h00, v, r);
        check(v, 32'h0);
        rd(8'h7C, v, r);
        check(r, 2'h2);
        check(v, 32'h0);
        wr(8'h7C, 32'hFFFFFFFF, r);
        check(r, 2'h2);
        // random pin levels, pin enable and software direction
        repeat (8) begin
            rb = $random(seed);
            digital_pin_six <= rb[0];
            digital_pin_seven <= rb[1];
            wr(8'h00, {16'h0, rb[3], rb[2], 14'h0}, r);
            wr(8'h20, {16'h0, rb[5], rb[4], 14'h0}, r);
            repeat (40) @(posedge aclk);
            rd(8'h10, v, r);
            check(v[4], dir_up(rb[2], rb[0], rb[3]));
            check(v[3], rb[0]);
            rd(8'h30, v, r);
            check(v[4], dir_up(rb[4], rb[1], rb[5]));
        end
        digital_pin_six <= 1'b0;
        digital_pin_seven <= 1'b1;
        // load 3, 0 counts down, 1 up: one terminal count per 4 ticks
        for (int c = 0; c < 2; c++) begin
            for (int m = 0; m < 4; m++) begin
                b = c ? 8'h20 : 8'h00;
                rb = $random(seed);
                wr(b + 8'h04, 32'h3, r);
                wr(b, {13'h0, 5'b11101, m[1], m[0], c ? 2'b10 : 2'b01,
                       rb[0], 4'h8, rb[1], c ? 4'h3 : 4'h0}, r);
                wr(b + 8'h10, 32'h3, r);
                repeat (32) @(posedge aclk);
                nt = 0; ns = 0; ng = 0; nh = 0;
                repeat (640) begin
                    @(posedge aclk);
                    t = c ? counter1_tc_out : counter0_tc_out;
                    s = c ? counter1_clk_src_mon : counter0_clk_src_mon;
                    g = c ? counter1_gate_in_mon : counter0_gate_in_mon;
                    nt += (t !== lt);
                    ns += (s !== ls);
                    ng += (g !== lg);
                    nh += (t === 1'b1);
                    lt = t; ls = s; lg = g;
                end
                check(c ? {counter1_tc_oe, counter1_mon_oe}
                        : {counter0_tc_oe, counter0_mon_oe}, 2'b11);
                check(near(ns, 80), 1'b1);
                check(near(ng, 40), 1'b1);
                check(near(nt, m[0] ? 10 : 20), 1'b1);
                if (!m[0]) check(nh > 320, m[1]);
                rd(b + 8'h10, v, r);
                check(v[1:0], {c[0], 1'b1});
                rd(b + 8'h0C, v, r);
                check(v <= 32'h3, 1'b1);
            end
        end
        // 20 MHz base: count every cycle
        wr(8'h00, {13'h0, 5'b11100, 4'b0011, 6'h0, 4'hA}, r);
        repeat (8) @(posedge aclk);
        nt = 0;
        repeat (64) begin
            @(posedge aclk);
            nt += (counter0_tc_out !== lt);
            lt = counter0_tc_out;
        end
        check(near(nt, 32), 1'b1);
        // divide by 1, by 16, random, then the slow base
        for (int i = 0; i < 5; i++) begin
            rb = $random(seed);
            m1 = i == 1 ? 4'hF : (i == 0 || i == 4) ? 4'h0 : rb[3:0];
            wr(8'h40, {25'h0, 1'b1, rb[4], i == 4, m1}, r);
            per = (i == 4 ? 200 : 2) * (int'(m1) + 1);
            repeat (2 * per) @(posedge aclk);
            nt = 0;
            repeat (8 * per) begin
                @(posedge aclk);
                nt += (divider_out === 1'b1 && lt === 1'b0);
                lt = divider_out;
            end
            check(divider_oe, 1'b1);
            check(near(nt, 8), 1'b1);
        end
        results;
    end

    // watchdog well beyond the roughly 9000 cycles the run needs
    initial begin
        #2000000;
        n_errors++;
        results;
    end
endmodule : general_purpose_counter_io_bench
`default_nettype wire
